// ===== core/bcc_charge_ctrl.sv
// Charge cycle controller top: registers, cycle state machine, targets
//
// Chosen here: the plain strobed port and the register offsets.
`default_nettype none

module bcc_charge_ctrl
    import bcc_pkg::*;
#(
    parameter int PULSE_CYC = INT_PULSE_CYC,
    parameter int BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic chargeEnablePin_b,
    input wire logic [NFLAG-1:0] analogFlags,
    input wire logic [7:0] chargeCurrentCode,
    output logic [1:0] chargePhaseStatus,
    output logic [15:0] chargeCurrentTarget,
    output logic [15:0] termCurrentTarget,
    output logic [15:0] chargeVoltageTarget,
    output logic rechargeThresholdSelect,
    output logic timerHalfRate,
    output logic batterySwitchOn,
    output logic batterySwitchLinear,
    output logic [7:0] batterySwitchVdsMin,
    output logic boostRun,
    output logic statPinOut,
    output logic statPinOe_b,
    output logic int_b
);
    // ------------------------------------------------------------
    // Reset release and input synchronisation
    // ------------------------------------------------------------
    logic [1:0] rstPipe;
    logic rstSync_b;
    logic [NFLAG:0] flags;
    logic doneFire;

    // Release is synchronised so all flops leave reset on one edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe[1];

    // Enable pin rides the same synchroniser as the comparators
    bcc_flag_sync #(.W(NFLAG + 1)) uSync (
        .ref_clk(ref_clk),
        .rstSync_b(rstSync_b),
        .rawFlags({chargeEnablePin_b, analogFlags}),
        .syncFlags(flags)
    );

    bcc_int_pulse #(.PULSE_CYC(PULSE_CYC)) uIrq (
        .ref_clk(ref_clk),
        .rstSync_b(rstSync_b),
        .fire(doneFire),
        .int_b(int_b)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bcc_state_t state;
        logic [7:0] ctrl;
        logic [7:0] charge_voltage_setting;
        logic [7:0] fast_charge_current_setting;
        logic [7:0] iterm;
        logic [7:0] ipre;
        logic [7:0] comp;
        logic [7:0] boost;
        logic [7:0] rdata;
        logic supplement;
        logic fire;
        logic [1:0] phase;
        logic [15:0] iTarget;
        logic [15:0] tTarget;
        logic [15:0] vTarget;
        logic halfRate;
        logic swOn;
        logic boostOn;
        logic statOe_b;
        logic blink;
        logic [23:0] blinkCnt;
    } bcc_top_t;

    bcc_top_t st, next_st;

    logic pinLow;
    logic chargeOk;
    logic startOk;
    logic inReg;
    logic termOk;
    logic [15:0] fastMa;
    logic [15:0] termMa;
    logic [15:0] irMv;
    logic [15:0] clampMv;
    logic [15:0] compMv;

    // Read decode, used for read data and the status view
    function automatic logic [7:0] readReg(input bcc_top_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_CTRL: v = s.ctrl;
            OFS_CHARGE_VOLTAGE_SETTING: v = s.charge_voltage_setting;
            OFS_FAST_CHARGE_CURRENT_SETTING: v = s.fast_charge_current_setting;
            OFS_ITERM: v = s.iterm;
            OFS_IPRE: v = s.ipre;
            OFS_COMP: v = s.comp;
            OFS_BOOST: v = s.boost;
            OFS_STATUS: v = {2'h0, s.boostOn, s.supplement, s.swOn, s.statOe_b, s.phase};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Qualification terms
    // ------------------------------------------------------------
    always_comb begin
        pinLow = !flags[NFLAG];
        // Bit and pin together enable the autonomous cycle
        chargeOk = st.ctrl[CTL_CHG_EN] && pinLow && flags[F_CONV]
            && (st.fast_charge_current_setting != 8'h00) && !st.ctrl[CTL_SW_DIS];
        // Start also needs thermistor window and no timer fault
        startOk = chargeOk && flags[F_TS_IN] && !flags[F_TMR_FAULT];
        inReg = flags[F_PWR_LIM] || flags[F_THERM];
        // Regulation and a cleared enable bit block termination
        termOk = st.ctrl[CTL_TERM_EN] && flags[F_I_LT_TERM]
            && flags[F_BAT_GT_RECHG] && !inReg;
    end

    // ------------------------------------------------------------
    // Targets: current by band and zone, voltage with compensation
    // ------------------------------------------------------------
    always_comb begin
        fastMa = 16'(st.fast_charge_current_setting) << CUR_LSB_SHIFT;
        termMa = 16'(st.iterm) << CUR_LSB_SHIFT;
        // Cool zone trims fast current
        if (flags[F_TS_COOL]) begin
            fastMa = st.ctrl[CTL_COOL_ISEL] ? 16'(fastMa / 16'h0005) : (fastMa >> 1);
            // Cool zone scales the termination level too
            termMa = st.ctrl[CTL_COOL_TSCALE] ? 16'(termMa / 16'h0005) : (termMa >> 1);
        end
        // 50 mA per code times 20 mOhm per code gives 1 mV per unit
        irMv = 16'(chargeCurrentCode) * 16'(st.comp[2:0]);
        clampMv = 16'(st.comp[5:3]) << CLAMP_LSB_SHIFT;
        compMv = (irMv < clampMv) ? irMv : clampMv;
    end

    // ------------------------------------------------------------
    // Next state: bus, cycle machine, supplement, pins
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.fire = 1'b0;
        next_st.rdata = 8'h00;
        // Registers apply on the next cycle, even mid-charge
        if (regWr) begin
            unique case (regAddr)
                OFS_CTRL: next_st.ctrl = regWdata;
                OFS_CHARGE_VOLTAGE_SETTING: next_st.charge_voltage_setting = regWdata;
                OFS_FAST_CHARGE_CURRENT_SETTING: next_st.fast_charge_current_setting = regWdata;
                OFS_ITERM: next_st.iterm = regWdata;
                OFS_IPRE: next_st.ipre = regWdata;
                OFS_COMP: next_st.comp = regWdata;
                OFS_BOOST: next_st.boost = regWdata;
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        if (regRd) begin
            next_st.rdata = readReg(st, regAddr);
        end

        // Cycle machine
        unique case (st.state)
            ST_IDLE: begin
                // Re-enable after done lands here first
                if (startOk) begin
                    next_st.state = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (!chargeOk) begin
                    next_st.state = ST_IDLE;
                end else if (!flags[F_TS_IN] || flags[F_TMR_FAULT]) begin
                    next_st.state = ST_SUSPEND;
                end else if (termOk) begin
                    next_st.state = ST_DONE;
                    next_st.fire = 1'b1;
                end
            end
            ST_SUSPEND: begin
                if (!chargeOk) begin
                    next_st.state = ST_IDLE;
                end else if (flags[F_TS_IN] && !flags[F_TMR_FAULT]) begin
                    next_st.state = ST_CHARGE;
                end
            end
            ST_DONE: begin
                if (!chargeOk) begin
                    next_st.state = ST_IDLE;
                end else if (!flags[F_BAT_GT_RECHG]) begin
                    next_st.state = ST_CHARGE;
                end
            end
        endcase

        // Supplement on when system sags, off at depletion
        if (flags[F_BAT_DEPL]) begin
            next_st.supplement = 1'b0;
        end else if (flags[F_SYS_LT_BAT]) begin
            next_st.supplement = 1'b1;
        end

        // Phase code and current by battery band
        if (st.state == ST_DONE) begin
            next_st.phase = PH_DONE;
        end else if (st.state == ST_IDLE) begin
            next_st.phase = PH_DISABLED;
        end else begin
            next_st.phase = flags[F_BAT_3V] ? PH_FAST : PH_PRE;
        end
        if (!flags[F_BAT_2V]) begin
            next_st.iTarget = SHORT_CUR_MA;
        end else if (!flags[F_BAT_3V]) begin
            next_st.iTarget = 16'(st.ipre) << CUR_LSB_SHIFT;
        end else begin
            next_st.iTarget = fastMa;
        end
        if (st.state != ST_CHARGE) begin
            next_st.iTarget = 16'h0000;
        end
        next_st.tTarget = termMa;
        next_st.vTarget = CHARGE_VOLTAGE_SETTING_BASE_MV + (16'(st.charge_voltage_setting) << CHARGE_VOLTAGE_SETTING_LSB_SHIFT) + compMv;
        // Warm derate unless warm select bit is set
        if (flags[F_TS_WARM] && !st.ctrl[CTL_WARM_VSEL]) begin
            next_st.vTarget = next_st.vTarget - WARM_DROP_MV;
        end
        next_st.halfRate = (st.state == ST_CHARGE) && inReg;

        // Switch off after done, supplement may reopen it
        next_st.swOn = !st.ctrl[CTL_SW_DIS] && (st.supplement
            || st.state == ST_CHARGE || st.state == ST_SUSPEND);
        // Boost runs only inside its window unless monitor off
        next_st.boostOn = st.boost[2] && ((st.boost[1:0] == BOOST_MON_OFF)
            || flags[F_TS_BOOST]);

        // Slow blink for faults; a 24-bit count covers half a second
        if (st.blinkCnt == 24'h000000) begin
            next_st.blinkCnt = 24'(BLINK_CYC - 1);
            next_st.blink = !st.blink;
        end else begin
            next_st.blinkCnt = st.blinkCnt - 24'h000001;
        end
        // Status pin: low charging, released done/off, blink on fault
        if (st.ctrl[CTL_STATUS_PIN_DISABLE]) begin
            next_st.statOe_b = 1'b1;
        end else if (st.state == ST_SUSPEND
                || (st.boost[2] && !st.boostOn && st.boost[1:0] != BOOST_MON_OFF)) begin
            next_st.statOe_b = st.blink;
        end else begin
            next_st.statOe_b = (st.state != ST_CHARGE);
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st <= '0;
            st.state <= ST_IDLE;
            // Parameter defaults after reset
            st.ctrl <= RST_CTRL;
            st.charge_voltage_setting <= RST_CHARGE_VOLTAGE_SETTING;
            st.fast_charge_current_setting <= RST_FAST_CHARGE_CURRENT_SETTING;
            st.iterm <= RST_ITERM;
            st.ipre <= RST_IPRE;
            st.comp <= RST_COMP;
            st.boost <= RST_BOOST;
            st.statOe_b <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs from flops, except the fixed Vds minimum and status pin level
    // ------------------------------------------------------------
    assign regRdata = st.rdata;
    assign chargePhaseStatus = st.phase;
    assign chargeCurrentTarget = st.iTarget;
    assign termCurrentTarget = st.tTarget;
    assign chargeVoltageTarget = st.vTarget;
    assign rechargeThresholdSelect = st.ctrl[CTL_RECHG_SEL];
    assign timerHalfRate = st.halfRate;
    assign batterySwitchOn = st.swOn;
    assign batterySwitchLinear = st.supplement;
    assign batterySwitchVdsMin = SW_VDS_MIN_MV;
    assign boostRun = st.boostOn;
    assign statPinOut = 1'b0;
    assign statPinOe_b = st.statOe_b;
    assign doneFire = st.fire;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_start;
        @(posedge ref_clk) disable iff (!rstSync_b)
        (st.state == ST_IDLE ##1 st.state == ST_CHARGE) |-> $past(startOk);
    endproperty
    a_start: assert property (p_start) else $error("start without qualification");

    property p_term;
        @(posedge ref_clk) disable iff (!rstSync_b)
        (st.state == ST_CHARGE ##1 st.state == ST_DONE) |-> $past(termOk);
    endproperty
    a_term: assert property (p_term) else $error("termination without its conditions");

    property p_doneIrq;
        @(posedge ref_clk) disable iff (!rstSync_b)
        (st.state == ST_CHARGE ##1 st.state == ST_DONE) |-> ##[1:3] !int_b;
    endproperty
    a_doneIrq: assert property (p_doneIrq) else $error("no interrupt on completion");

    property p_donePhase;
        @(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_DONE ##1 st.state == ST_DONE |-> chargePhaseStatus == PH_DONE;
    endproperty
    a_donePhase: assert property (p_donePhase) else $error("done phase code wrong");

    property p_recharge;
        @(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_DONE && chargeOk && !flags[F_BAT_GT_RECHG] |=> st.state == ST_CHARGE;
    endproperty
    a_recharge: assert property (p_recharge) else $error("no automatic recharge");

    property p_deplete;
        @(posedge ref_clk) disable iff (!rstSync_b)
        flags[F_BAT_DEPL] |=> !batterySwitchLinear;
    endproperty
    a_deplete: assert property (p_deplete) else $error("supplement kept past depletion");

    property p_doneSwitch;
        @(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_DONE && !st.supplement |=> !batterySwitchOn;
    endproperty
    a_doneSwitch: assert property (p_doneSwitch) else $error("switch on after done");

    property p_tsSuspend;
        @(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_CHARGE && chargeOk && !flags[F_TS_IN] |=> st.state == ST_SUSPEND;
    endproperty
    a_tsSuspend: assert property (p_tsSuspend) else $error("charging outside window");

    property p_boost;
        @(posedge ref_clk) disable iff (!rstSync_b)
        st.boost[1:0] != BOOST_MON_OFF && !flags[F_TS_BOOST] |=> !boostRun;
    endproperty
    a_boost: assert property (p_boost) else $error("boost outside window");

    property p_statLow;
        @(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_CHARGE && !st.ctrl[CTL_STATUS_PIN_DISABLE] && !st.boost[2] |=> !statPinOe_b;
    endproperty
    a_statLow: assert property (p_statLow) else $error("status pin not low");

    c_done: cover property (@(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_CHARGE ##1 st.state == ST_DONE);
    c_recharge: cover property (@(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_DONE ##1 st.state == ST_CHARGE);
    c_suspend: cover property (@(posedge ref_clk) disable iff (!rstSync_b)
        st.state == ST_SUSPEND ##1 st.state == ST_CHARGE);
endmodule

`default_nettype wire

// ===== core/bcc_pkg.sv
// Constants, register map and types for the charge cycle controller
// Behaviour
// - Supplement mode: switch on, 30 mV drop
// - Leave supplement below battery depletion threshold
// - Enable bit and pin run cycle autonomously
// - Reset defaults 4.208 V, 2.048 A, 256 mA
// - Start needs converter, enable, current, no faults
// - Terminate: low current, full battery, no regulation
// - Auto recharge below selectable recharge threshold
// - Toggling enable pin or bit restarts
// - Status pin low/high/blink, disable bit
// - Phase code 00/01/10/11
// - Completion sets done and interrupts host
// - Current chosen by battery voltage band
// - Regulation suspends termination, halves timer rate
// - After done switch off, supplement still allowed
// - Termination enable zero blocks termination
// - Target voltage adds clamped IR compensation
// - Charge only inside T1-T5, else suspend
// - Warm zone lowers target 200 mV
// - Cool zone current 20% or 50%
// - Cool termination scaled, warm unscaled
// - Boost suspended outside window unless code 11
// - Interrupt is 256 us low pulse
`default_nettype none

package bcc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHARGE_VOLTAGE_SETTING = 8'h01;
    localparam logic [7:0] OFS_FAST_CHARGE_CURRENT_SETTING = 8'h02;
    localparam logic [7:0] OFS_ITERM = 8'h03;
    localparam logic [7:0] OFS_IPRE = 8'h04;
    localparam logic [7:0] OFS_COMP = 8'h05;
    localparam logic [7:0] OFS_BOOST = 8'h06;
    localparam logic [7:0] OFS_STATUS = 8'h07;
    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTL_CHG_EN = 0;
    localparam int CTL_TERM_EN = 1;
    localparam int CTL_STATUS_PIN_DISABLE = 2;
    localparam int CTL_SW_DIS = 3;
    localparam int CTL_RECHG_SEL = 4;
    localparam int CTL_WARM_VSEL = 5;
    localparam int CTL_COOL_ISEL = 6;
    localparam int CTL_COOL_TSCALE = 7;
    localparam logic [7:0] RST_CTRL = 8'h03;
    localparam logic [7:0] RST_CHARGE_VOLTAGE_SETTING = 8'h17;   // 3840 + 23*16 = 4208 mV
    localparam logic [7:0] RST_FAST_CHARGE_CURRENT_SETTING = 8'h20;   // 32*64 = 2048 mA
    localparam logic [7:0] RST_ITERM = 8'h04;  // 4*64 = 256 mA
    localparam logic [7:0] RST_IPRE = 8'h02;   // 2*64 = 128 mA
    localparam logic [7:0] RST_COMP = 8'h00;
    localparam logic [7:0] RST_BOOST = 8'h00;
    // ------------------------------------------------------------
    // Scales and fixed values
    // ------------------------------------------------------------
    localparam logic [15:0] CHARGE_VOLTAGE_SETTING_BASE_MV = 16'h0F00;  // 3840 mV
    localparam int CHARGE_VOLTAGE_SETTING_LSB_SHIFT = 4;                // 16 mV steps
    localparam int CUR_LSB_SHIFT = 6;                 // 64 mA steps
    localparam int CLAMP_LSB_SHIFT = 5;               // 32 mV steps
    localparam logic [15:0] WARM_DROP_MV = 16'h00C8;  // 200 mV
    localparam logic [15:0] SHORT_CUR_MA = 16'h0064;  // Short battery current
    localparam logic [7:0] SW_VDS_MIN_MV = 8'h1E;     // 30 mV
    localparam logic [1:0] BOOST_MON_OFF = 2'h3;
    localparam logic [1:0] PH_DISABLED = 2'h0;
    localparam logic [1:0] PH_PRE = 2'h1;
    localparam logic [1:0] PH_FAST = 2'h2;
    localparam logic [1:0] PH_DONE = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int INT_PULSE_US = 256;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_KHZ / 1000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
    // Synchronised flag positions
    localparam int NFLAG = 14;
    localparam int F_CONV = 0;
    localparam int F_SYS_LT_BAT = 1;
    localparam int F_BAT_DEPL = 2;
    localparam int F_BAT_2V = 3;
    localparam int F_BAT_3V = 4;
    localparam int F_I_LT_TERM = 5;
    localparam int F_BAT_GT_RECHG = 6;
    localparam int F_PWR_LIM = 7;
    localparam int F_THERM = 8;
    localparam int F_TS_IN = 9;
    localparam int F_TS_COOL = 10;
    localparam int F_TS_WARM = 11;
    localparam int F_TS_BOOST = 12;
    localparam int F_TMR_FAULT = 13;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHARGE = 4'h2,
        ST_SUSPEND = 4'h4,
        ST_DONE = 4'h8
    } bcc_state_t;
endpackage

`default_nettype wire

// ===== core/bcc_flag_sync.sv
// Two-flop synchroniser bank for comparator flags
`default_nettype none

module bcc_flag_sync
    import bcc_pkg::*;
#(
    parameter int W = NFLAG
) (
    input wire logic ref_clk,
    input wire logic rstSync_b,
    input wire logic [W-1:0] rawFlags,
    output logic [W-1:0] syncFlags
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } bcc_sync_t;

    bcc_sync_t st, next_st;

    // Stage one feeds only stage two
    always_comb begin
        next_st.stage1 = rawFlags;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncFlags = st.stage2;
endmodule

`default_nettype wire

// ===== core/bcc_int_pulse.sv
// Fixed-length active-low interrupt pulse generator
`default_nettype none

module bcc_int_pulse
    import bcc_pkg::*;
#(
    parameter int PULSE_CYC = INT_PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic rstSync_b,
    input wire logic fire,
    output logic int_b
);
    typedef struct packed {
        logic [15:0] count;
        logic pin_b;
    } bcc_pulse_t;

    bcc_pulse_t st, next_st;

    // Retrigger during a pulse is merged into the running pulse
    always_comb begin
        next_st = st;
        if (fire && st.pin_b) begin
            next_st.count = 16'(PULSE_CYC - 1);
            next_st.pin_b = 1'b0;
        end else if (!st.pin_b) begin
            if (st.count == 16'h0000) begin
                next_st.pin_b = 1'b1;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st <= '{count: 16'h0000, pin_b: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign int_b = st.pin_b;

    property p_pulseLen;
        @(posedge ref_clk) disable iff (!rstSync_b)
        $fell(st.pin_b) |-> (!st.pin_b)[*8];
    endproperty
    a_pulseLen: assert property (p_pulseLen) else $error("interrupt pulse too short");
endmodule

`default_nettype wire

// ===== tb/bcc_host_model.sv
// Host model that drives the controller register port
`default_nettype none
module bcc_host_model (
    input wire logic ref_clk,
    output var logic [7:0] regAddr,
    output var logic [7:0] regWdata,
    output var logic regWr,
    output var logic regRd,
    input wire logic [7:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus until the first request
    initial begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // One-cycle write strobe; parameters may change at any time
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the charge cycle controller
`default_nettype none
module tb;
    import bcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst_b, pinEn_b;
    logic [NFLAG-1:0] flags;
    logic [7:0] curCode, regAddr, regWdata, regRdata, vdsMin;
    logic regWr, regRd, halfRate, statOe_b, int_b, rechgSel, swOn, swLin, boostOn, statOut;
    logic [1:0] phase;
    logic [15:0] iTgt, tTgt, vTgt;
    int errorCnt = 0;
    int checks = 0;
    bcc_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    // Short pulse and blink counts keep the run brief
    bcc_charge_ctrl #(.PULSE_CYC(16), .BLINK_CYC(8)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .chargeEnablePin_b(pinEn_b), .analogFlags(flags),
        .chargeCurrentCode(curCode), .chargePhaseStatus(phase), .chargeCurrentTarget(iTgt),
        .termCurrentTarget(tTgt), .chargeVoltageTarget(vTgt),
        .rechargeThresholdSelect(rechgSel), .timerHalfRate(halfRate),
        .batterySwitchOn(swOn), .batterySwitchLinear(swLin), .batterySwitchVdsMin(vdsMin),
        .boostRun(boostOn), .statPinOut(statOut), .statPinOe_b(statOe_b),
        .int_b(int_b));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // Flags pass two sync flops before the state machine sees them
    task automatic step(input logic [NFLAG-1:0] f);
        @(posedge ref_clk);
        flags <= f;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #100000;
        errorCnt++;
        give_verdict();
    end
    // Main sequence
    initial begin
        logic [7:0] ad [5] = '{OFS_CTRL, OFS_CHARGE_VOLTAGE_SETTING, OFS_FAST_CHARGE_CURRENT_SETTING, OFS_ITERM, 8'h3F};
        logic [7:0] ex [5] = '{8'h03, 8'h17, 8'h20, 8'h04, 8'h00};
        logic [7:0] d;
        int n;
        rst_b = 1'b0;
        pinEn_b = 1'b1;
        flags = '0;
        curCode = 8'h0A;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            host.rd(ad[i], d);
            chk("reg", {8'h00, ex[i]}, {8'h00, d});
        end
        chk("vds min", 16'h001E, {8'h00, vdsMin});
        chk("stat out", 16'h0000, 16'(statOut));
        chk("rechg sel", 16'h0000, 16'(rechgSel));
        @(posedge ref_clk);
        pinEn_b <= 1'b0;
        step(14'h0201);
        chk("short current", SHORT_CUR_MA, iTgt);
        step(14'h0209);
        chk("sw charge", 16'h0001, 16'(swOn));
        chk("phase pre", 16'h0001, 16'(phase));
        chk("pre current", 16'h0080, iTgt);
        chk("stat drive", 16'h0000, 16'(statOe_b));
        step(14'h0219);
        chk("phase fast", 16'h0002, 16'(phase));
        chk("fast current", 16'h0800, iTgt);
        chk("volt target", 16'h1070, vTgt);
        chk("term current", 16'h0100, tTgt);
        step(14'h0619);
        chk("cool current", 16'h0400, iTgt);
        chk("cool term", 16'h0080, tTgt);
        step(14'h0A19);
        chk("warm volt", 16'h0FA8, vTgt);
        chk("warm term", 16'h0100, tTgt);
        step(14'h02F9);
        chk("phase in reg", 16'h0002, 16'(phase));
        chk("half rate", 16'h0001, 16'(halfRate));
        @(posedge ref_clk);
        flags <= 14'h0279;
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            n += int'(int_b === 1'b0);
        end
        chk("int low cycles", 16'h0010, n[15:0]);
        chk("phase done", 16'h0003, 16'(phase));
        chk("stat release", 16'h0001, 16'(statOe_b));
        chk("sw done", 16'h0000, 16'(swOn));
        step(14'h0239);
        chk("phase rechg", 16'h0002, 16'(phase));
        host.wr(OFS_CTRL, 8'h01);
        step(14'h0279);
        chk("phase no term", 16'h0002, 16'(phase));
        host.wr(OFS_CTRL, 8'h00);
        step(14'h0279);
        chk("phase off", 16'h0000, 16'(phase));
        host.wr(OFS_CTRL, 8'h13);
        step(14'h0279);
        chk("phase restart", 16'h0003, 16'(phase));
        chk("rechg sel set", 16'h0001, 16'(rechgSel));
        step(14'h027B);
        chk("supplement", 16'h0001, 16'(swLin));
        chk("sw supplement", 16'h0001, 16'(swOn));
        step(14'h027F);
        chk("depleted", 16'h0000, 16'(swLin));
        chk("sw depleted", 16'h0000, 16'(swOn));
        host.wr(OFS_COMP, 8'h0F);
        step(14'h027F);
        chk("clamp volt", 16'h1090, vTgt);
        host.wr(OFS_COMP, 8'h0B);
        host.rd(OFS_COMP, d);
        chk("comp reg", 16'h000B, {8'h00, d});
        step(14'h027F);
        chk("ir volt", 16'h108E, vTgt);
        host.wr(OFS_BOOST, 8'h07);
        step(14'h027F);
        chk("boost mon off", 16'h0001, 16'(boostOn));
        host.wr(OFS_BOOST, 8'h04);
        step(14'h027F);
        chk("boost window", 16'h0000, 16'(boostOn));
        give_verdict();
    end
endmodule
`default_nettype wire
